/* File: src/eba_ctrl.sv */
/*
  nonvolatile byte access controller: 64-byte store reached through
  address, value and control registers on the cpu i/o port.
  assumes the cpu honours cpu_stall and gives a calibrated oscillator
  tick (one pulse per microsecond) as osc_tick_pin from another domain.
*/
// How it works
// R1 - a separate 64-byte store, each byte read and written alone
// R2 - address, value and control sit in the cpu i/o space
// R3 - a read strobe stalls the cpu four cycles
// R4 - a program strobe stalls the cpu two cycles
// R5 - mode 00, strobe within four cycles of master enable: erase then write
// R6 - program strobe stays set until the operation ends, usable as busy
// R7 - while programming, no other store operation starts
// R8 - mode 01 erases the addressed byte only
// R9 - mode 10 writes the value without erasing first
// R10 - software must erase before a write-only, else data is lost
// R11 - software loads address and value before atomic or write-only
// R12 - software loads address before erase-only; value unused
// R13 - programming duration is timed from the calibrated oscillator
// R14 - software should block interrupts around the timed sequence
// R15 - atomic takes 3.4 ms, split ops 1.8 ms, mode 11 reserved
// R16 - while program strobe is set, mode field writes are ignored
// R17 - ready interrupt is a level while enabled and store is ready
// R18 - read strobe loads the addressed byte into the value register
// R19 - master enable self-clears after four cycles; strobe without it ignored
// R20 - reserved mode starts nothing and leaves contents unchanged
`timescale 1ns/100ps
module eba_ctrl
  import eba_pkg::*;
(
  input  wire logic                 mclk,
  input  wire logic                 sys_rst,
  input  wire logic [eba_pkg::ADDR_W-1:0] io_addr,
  input  wire logic [7:0]           io_wdata,
  input  wire logic                 io_wr,
  input  wire logic                 io_rd,
  input  wire logic                 global_int_en,
  input  wire logic                 osc_tick_pin,
  output logic      [7:0]           io_rdata,
  output logic                      cpu_stall,
  output logic                      ready_irq
);

  // ----------------------------------------------------------------
  // storage and registers
  // ----------------------------------------------------------------
  logic [7:0] mem_q [64];                 // R1
  logic [5:0] addr_q;
  logic [7:0] value_q;
  logic [1:0] mode_q;
  logic       int_en_q;
  logic       master_q;
  logic [2:0] master_cnt_q;
  // two-state so the power-up reset sees the store idle
  bit         prog_q;
  logic [2:0] stall_cnt_q;
  // operation captured at the strobe, safe from later register writes
  logic [1:0] op_q;
  logic [5:0] op_addr_q;
  logic [7:0] op_value_q;
  // oscillator synchroniser and edge stage
  logic       osc_s1_q;
  logic       osc_s2_q;
  logic       osc_s3_q;

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  // an access strobe aimed at one i/o offset
  function automatic logic reg_hit
  (
    input logic              strobe,
    input logic [ADDR_W-1:0] addr,
    input logic [ADDR_W-1:0] offset
  );
    reg_hit = strobe && (addr == offset);
  endfunction

  // programming length in oscillator ticks for a mode code
  function automatic logic [TICK_W-1:0] prog_ticks
  (
    input logic [1:0] mode
  );
    if (mode == MODE_ATOMIC)
      prog_ticks = TICK_W'(ATOMIC_TICKS);
    else
      prog_ticks = TICK_W'(SPLIT_TICKS);
  endfunction

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  // register writes
  wire        wr_ctrl  = reg_hit(io_wr, io_addr, OFF_CONTROL); // R2
  wire        wr_value = reg_hit(io_wr, io_addr, OFF_VALUE);
  wire        wr_addr  = reg_hit(io_wr, io_addr, OFF_ADDRESS);
  wire        busy     = prog_q;

  // strobes that start work, refused while busy
  wire        rd_go    = wr_ctrl && io_wdata[BIT_READ_STROBE]
                         && !busy;                            // R7
  wire        pg_req   = wr_ctrl && io_wdata[BIT_PROGRAM_STROBE];
  wire        pg_go    = pg_req && master_q && !busy
                         && (mode_q != MODE_RESERVED);        // R19 R20
  wire        me_set   = wr_ctrl && io_wdata[BIT_MASTER_ENABLE];

  // mode field, tick edge and control read view
  wire [1:0]  mode_new = io_wdata[BIT_MODE_HI:BIT_MODE_LO];
  wire        osc_tick = osc_s2_q && !osc_s3_q;
  wire [7:0]  ctrl_rd  = {2'b00, mode_q, int_en_q, master_q, prog_q, 1'b0};
  wire [TICK_W-1:0] prog_len = prog_ticks(mode_q);            // R15
  wire        tmr_done;
  wire        tmr_busy;
  // the timer keeps its count through a reset that lands mid-operation
  wire        tmr_rst  = sys_rst && !prog_q;

  // ----------------------------------------------------------------
  // oscillator tick synchroniser
  // ----------------------------------------------------------------
  // ticks pause while reset is held, stretching a running operation
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      osc_s1_q <= 1'b0;
      osc_s2_q <= 1'b0;
      osc_s3_q <= 1'b0;
    end
    else
    begin
      osc_s1_q <= osc_tick_pin;
      osc_s2_q <= osc_s1_q;
      osc_s3_q <= osc_s2_q;
    end
  end

  // programming duration from the oscillator
  eba_prog_timer #(.TW(TICK_W)) u_timer
  (
    .mclk     (mclk),
    .sys_rst  (tmr_rst),
    .start    (pg_go),
    .length   (prog_len),
    .osc_tick (osc_tick),                                     // R13
    .busy     (tmr_busy),
    .done     (tmr_done)
  );

  // ----------------------------------------------------------------
  // address and value registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      addr_q  <= '0;
      value_q <= '0;
    end
    else
    begin
      if (wr_addr)
        addr_q <= io_wdata[5:0];
      if (rd_go)
        value_q <= mem_q[addr_q];                             // R18
      else if (wr_value)
        value_q <= io_wdata;
    end
  end

  // ----------------------------------------------------------------
  // control register fields
  // ----------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      int_en_q <= 1'b0;
      if (!prog_q)
        mode_q <= MODE_RESET;
    end
    else if (wr_ctrl)
    begin
      int_en_q <= io_wdata[BIT_READY_INT_EN];
      if (!prog_q)
        mode_q <= mode_new;                                   // R16
    end
  end

  // master enable with four-cycle self clear
  // master enable in the same write as a program strobe is not taken; the strobe is judged on the earlier enable
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      master_q     <= 1'b0;
      master_cnt_q <= '0;
    end
    else if (me_set && !pg_req)
    begin
      master_q     <= 1'b1;
      master_cnt_q <= 3'(MASTER_WINDOW_CYC);
    end
    else if (pg_req || master_cnt_q == 3'h1)
    begin
      master_q     <= 1'b0;                                   // R19
      master_cnt_q <= '0;
    end
    else if (master_cnt_q != 3'h0)
      master_cnt_q <= master_cnt_q - 3'h1;
  end

  // ----------------------------------------------------------------
  // program strobe and operation capture
  // ----------------------------------------------------------------
  // a reset mid-operation keeps the strobe set until the timer ends
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      prog_q     <= prog_q && tmr_busy;  // running op completes
      op_q       <= op_q;
      op_addr_q  <= op_addr_q;
      op_value_q <= op_value_q;
    end
    else if (pg_go)
    begin
      prog_q     <= 1'b1;                                     // R5 R6
      op_q       <= mode_q;
      op_addr_q  <= addr_q;
      op_value_q <= value_q;
    end
    else if (tmr_done)
      prog_q <= 1'b0;                                         // R6
  end

  // commit the byte when the timed operation ends
  // write-only can only clear bits, so an unerased byte is lost
  always_ff @(posedge mclk)
  begin
    if (tmr_done && prog_q)
    begin
      unique case (op_q)
        MODE_ATOMIC: mem_q[op_addr_q] <= op_value_q;          // R5
        MODE_ERASE:  mem_q[op_addr_q] <= ERASED_BYTE;         // R8
        MODE_WRITE:  mem_q[op_addr_q] <= mem_q[op_addr_q]
                                         & op_value_q;        // R9
        default:     mem_q[op_addr_q] <= mem_q[op_addr_q];    // R20
      endcase
    end
  end

  // ----------------------------------------------------------------
  // cpu stall, read data, ready interrupt
  // ----------------------------------------------------------------
  // the count covers the cycles after the one that raises the stall
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      stall_cnt_q <= '0;
      cpu_stall   <= 1'b0;
    end
    else if (rd_go)
    begin
      stall_cnt_q <= 3'(READ_STALL_CYC - 1);                  // R3
      cpu_stall   <= 1'b1;
    end
    else if (pg_go)
    begin
      stall_cnt_q <= 3'(PROG_STALL_CYC - 1);                  // R4
      cpu_stall   <= 1'b1;
    end
    else if (stall_cnt_q != 3'h0)
      stall_cnt_q <= stall_cnt_q - 3'h1;
    else
      cpu_stall <= 1'b0;
  end

  // read answer one cycle after the strobe
  // unmapped offsets and idle cycles read as zero
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      io_rdata <= '0;
    else if (io_rd)
    begin
      unique case (io_addr)
        OFF_CONTROL: io_rdata <= ctrl_rd;
        OFF_VALUE:   io_rdata <= value_q;
        OFF_ADDRESS: io_rdata <= {2'b00, addr_q};
        default:     io_rdata <= 8'h00;
      endcase
    end
    else
      io_rdata <= 8'h00;
  end

  // level interrupt while ready
  // drops the cycle after a start, returns the cycle after the end
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      ready_irq <= 1'b0;
    else
      ready_irq <= int_en_q && global_int_en && !prog_q;      // R17
  end

endmodule

/* File: src/eba_pkg.sv */
/*
  package for the nonvolatile byte access controller: register offsets,
  control field positions, reset values, mode codes and timing constants.
  assumes a 20 MHz cpu clock and a calibrated oscillator tick input.
*/
package eba_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int        ADDR_W          = 6;
  localparam logic [5:0] OFF_CONTROL    = 6'h1C;
  localparam logic [5:0] OFF_VALUE      = 6'h1D;
  localparam logic [5:0] OFF_ADDRESS    = 6'h1E;

  // control register fields
  localparam int BIT_READ_STROBE        = 0;
  localparam int BIT_PROGRAM_STROBE     = 1;
  localparam int BIT_MASTER_ENABLE      = 2;
  localparam int BIT_READY_INT_EN       = 3;
  localparam int BIT_MODE_LO            = 4;
  localparam int BIT_MODE_HI            = 5;

  // ----------------------------------------------------------------
  // modes
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_ATOMIC    = 2'h0;
  localparam logic [1:0] MODE_ERASE     = 2'h1;
  localparam logic [1:0] MODE_WRITE     = 2'h2;
  localparam logic [1:0] MODE_RESERVED  = 2'h3;
  localparam logic [1:0] MODE_RESET     = 2'h0;

  localparam logic [7:0] ERASED_BYTE    = 8'hFF;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ                = 20;
  localparam int MASTER_WINDOW_CYC      = 4;
  localparam int READ_STALL_CYC         = 4;
  localparam int PROG_STALL_CYC         = 2;
  // programming times in microseconds, counted in oscillator ticks of 1 us
  localparam int ATOMIC_TIME_US         = 3400;
  localparam int SPLIT_TIME_US          = 1800;
  localparam int OSC_TICK_US            = 1;
  localparam int ATOMIC_TICKS           = ATOMIC_TIME_US / OSC_TICK_US;
  localparam int SPLIT_TICKS            = SPLIT_TIME_US / OSC_TICK_US;
  localparam int TICK_W                 = 12;

endpackage

/* File: src/eba_prog_timer.sv */
/*
  programming duration timer. counts oscillator ticks from a start pulse
  and pulses done when the chosen length has passed.
  assumes osc_tick is a one-cycle enable already in the mclk domain.
*/
`timescale 1ns/100ps
module eba_prog_timer
#(
  parameter int TW = 12
)
(
  input  wire logic          mclk,
  input  wire logic          sys_rst,
  input  wire logic          start,
  input  wire logic [TW-1:0] length,
  input  wire logic          osc_tick,
  output logic               busy,
  output logic               done
);

  logic [TW-1:0] cnt_q;

  // ----------------------------------------------------------------
  // tick counter
  // ----------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      cnt_q <= '0;
      busy  <= 1'b0;
      done  <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (start)
      begin
        cnt_q <= length;
        busy  <= 1'b1;
      end
      else if (busy && osc_tick)
      begin
        if (cnt_q <= TW'(1))
        begin
          busy <= 1'b0;
          done <= 1'b1;
        end
        cnt_q <= cnt_q - TW'(1);
      end
    end
  end

endmodule

/* File: test/eba_osc_model.sv */
/* calibrated oscillator model: free-running tick pin.
   assumes PERIOD in ns is well above two mclk periods. */
`timescale 1ns/100ps
module eba_osc_model
#(
  parameter int PERIOD = 230
)
(
  output logic osc_tick_pin
);
  // free-running tick, one rising edge each period
  initial
  begin
    osc_tick_pin = 1'b0;
    #7;
    forever
    begin
      #(PERIOD - 100) osc_tick_pin = 1'b1;
      #100 osc_tick_pin = 1'b0;
    end
  end
endmodule

/* File: test/eba_ctrl_asserts.sv */
/* port checker for eba_ctrl.
   assumes the bind below reaches every eba_ctrl. */
`timescale 1ns/100ps
module eba_ctrl_asserts
(
  input wire logic                       mclk,
  input wire logic                       sys_rst,
  input wire logic [eba_pkg::ADDR_W-1:0] io_addr,
  input wire logic [7:0]                 io_wdata,
  input wire logic                       io_wr,
  input wire logic                       io_rd,
  input wire logic                       global_int_en,
  input wire logic                       osc_tick_pin,
  input wire logic [7:0]                 io_rdata,
  input wire logic                       cpu_stall,
  input wire logic                       ready_irq
);
  import eba_pkg::*;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);
  // ------------------------------------------------------------
  // master enable age
  // ------------------------------------------------------------
  logic       ctl_wr;
  logic [3:0] age_q;
  assign ctl_wr = io_wr && io_addr == OFF_CONTROL;
  // cycles since the last master enable write, saturating
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      age_q <= 4'hF;
    else if (ctl_wr && io_wdata[2:1] == 2'b10)
      age_q <= 4'h0;
    else if (age_q != 4'hF)
      age_q <= age_q + 4'h1;
  end
  sequence s_rd_go;
    ctl_wr && io_wdata[1:0] == 2'b01 ##1 $rose(cpu_stall);
  endsequence
  sequence s_pg_go;
    ctl_wr && io_wdata[1:0] == 2'b10 ##1 $rose(cpu_stall);
  endsequence
  property p_rd_idle;
    !$past(io_rd) |-> io_rdata == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data outside read slot");
  property p_rd_stall;
    s_rd_go |-> cpu_stall[*4] ##1 !cpu_stall;
  endproperty
  a_rd_stall: assert property (p_rd_stall)
    else $error("read stall length");
  property p_pg_stall;
    s_pg_go |-> cpu_stall[*2] ##1 !cpu_stall;
  endproperty
  a_pg_stall: assert property (p_pg_stall)
    else $error("program stall length");
  property p_cause;
    $rose(cpu_stall) |-> $past(ctl_wr);
  endproperty
  a_cause: assert property (p_cause)
    else $error("stall without control write");
  property p_no_master;
    ctl_wr && io_wdata[1:0] == 2'b10 && age_q > 4'h3
      |=> !$rose(cpu_stall);
  endproperty
  a_no_master: assert property (p_no_master)
    else $error("program started without master enable");
  property p_reserved;
    ctl_wr && io_wdata[5:4] == 2'b11 && io_wdata[1:0] == 2'b10
      |=> !$rose(cpu_stall);
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved mode started");
  property p_irq_gie;
    ready_irq |-> $past(global_int_en);
  endproperty
  a_irq_gie: assert property (p_irq_gie)
    else $error("ready irq without global enable");
  property p_irq_busy;
    s_pg_go |-> ##1 !ready_irq;
  endproperty
  a_irq_busy: assert property (p_irq_busy)
    else $error("ready irq while programming");
endmodule

bind eba_ctrl eba_ctrl_asserts u_chk (.mclk(mclk), .sys_rst(sys_rst),
  .io_addr(io_addr), .io_wdata(io_wdata), .io_wr(io_wr), .io_rd(io_rd),
  .global_int_en(global_int_en), .osc_tick_pin(osc_tick_pin),
  .io_rdata(io_rdata), .cpu_stall(cpu_stall), .ready_irq(ready_irq));

/* File: test/tb.sv */
/* bench for eba_ctrl: register tasks, program and read checks.
   assumes eba_osc_model as the oscillator. */
`timescale 1ns/100ps
module tb;
  import eba_pkg::*;
  localparam int P = 230;
  logic       mclk, sys_rst, io_wr, io_rd, gie, tick, stall, irq;
  logic [5:0] io_addr;
  logic [7:0] io_wdata, io_rdata, v;
  int         fails, comparisons;
  realtime    t0;
  eba_ctrl dut (.mclk(mclk), .sys_rst(sys_rst), .io_addr(io_addr),
    .io_wdata(io_wdata), .io_wr(io_wr), .io_rd(io_rd),
    .global_int_en(gie), .osc_tick_pin(tick), .io_rdata(io_rdata),
    .cpu_stall(stall), .ready_irq(irq));
  eba_osc_model #(.PERIOD(P)) osc (.osc_tick_pin(tick));
  // ------------------------------------------------------------
  // clock and tasks
  // ------------------------------------------------------------
  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  task stop_test;
    $display("fails %0d comparisons %0d", fails, comparisons);
    if (fails == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fails++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // wait out a cpu stall as the core would
  task settle;
    @(posedge mclk);
    #1;
    while (stall === 1'b1)
    begin
      @(posedge mclk);
      #1;
    end
  endtask
  task wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge mclk);
    io_addr <= a;
    io_wdata <= d;
    io_wr <= 1'b1;
    @(posedge mclk);
    io_wr <= 1'b0;
    settle();
  endtask
  task rd(input logic [5:0] a);
    @(posedge mclk);
    io_addr <= a;
    io_rd <= 1'b1;
    @(posedge mclk);
    io_rd <= 1'b0;
    #1 v = io_rdata;
    settle();
  endtask
  // master enable then program strobe, back to back
  task arm(input logic [7:0] d);
    @(posedge mclk);
    io_addr <= OFF_CONTROL;
    io_wdata <= {d[7:4], 4'hC};
    io_wr <= 1'b1;
    @(posedge mclk);
    io_wdata <= d;
    @(posedge mclk);
    io_wr <= 1'b0;
    settle();
  endtask
  task getb(input logic [7:0] a);
    wr(OFF_ADDRESS, a);
    wr(OFF_CONTROL, 8'h09);
    rd(OFF_VALUE);
  endtask
  // program byte 5, poke mode while busy, time the operation
  task prog(input logic [1:0] m, input logic [7:0] d, input int n);
    int k;
    wr(OFF_ADDRESS, 8'h05);
    wr(OFF_VALUE, d);
    arm({2'b00, m, 4'hA});
    t0 = $realtime;
    chk({7'h0, irq}, {7'h0, n == 0});
    wr(OFF_CONTROL, 8'h3B);
    k = 0;
    rd(OFF_CONTROL);
    while (v[1] === 1'b1 && k < 20000)
    begin
      rd(OFF_CONTROL);
      k++;
    end
    chk(v, {2'b00, m, 4'h8});
    chk({7'h0, $realtime - t0 > (n - 2) * P &&
      $realtime - t0 < (n + 3) * P}, 8'h01);
    chk({7'h0, irq}, 8'h01);
    rd(OFF_VALUE);
    chk(v, (n == 0) ? 8'h3C : d);
  endtask
  // main sequence
  initial
  begin
    io_wr = 1'b0;
    io_rd = 1'b0;
    io_addr = 6'h00;
    io_wdata = 8'h00;
    gie = 1'b1;
    sys_rst = 1'b1;
    repeat (3) @(posedge mclk);
    sys_rst <= 1'b0;
    rd(OFF_CONTROL);
    chk(v, 8'h00);
    rd(6'h1F);
    chk(v, 8'h00);
    wr(OFF_ADDRESS, 8'hFF);
    rd(OFF_ADDRESS);
    chk(v, 8'h3F);
    prog(MODE_ATOMIC, 8'hA5, ATOMIC_TICKS);
    getb(8'h05);
    chk(v, 8'hA5);
    prog(MODE_ERASE, 8'h00, SPLIT_TICKS);
    getb(8'h05);
    chk(v, ERASED_BYTE);
    prog(MODE_WRITE, 8'h3C, SPLIT_TICKS);
    getb(8'h05);
    chk(v, 8'h3C);
    prog(MODE_RESERVED, 8'h00, 0);
    getb(8'h05);
    chk(v, 8'h3C);
    // erase with a reset landing mid-operation: it still commits
    arm(8'h12);
    sys_rst <= 1'b1;
    repeat (3) @(posedge mclk);
    sys_rst <= 1'b0;
    rd(OFF_CONTROL);
    chk(v, 8'h12);
    while (v[1] === 1'b1)
      rd(OFF_CONTROL);
    getb(8'h05);
    chk(v, ERASED_BYTE);
    wr(OFF_CONTROL, 8'h0C);
    repeat (8) @(posedge mclk);
    wr(OFF_CONTROL, 8'h0A);
    rd(OFF_CONTROL);
    chk(v, 8'h08);
    gie <= 1'b0;
    repeat (3) @(posedge mclk);
    chk({7'h0, irq}, 8'h00);
    stop_test();
  end
  // watchdog
  initial
  begin
    #4000000;
    fails++;
    stop_test();
  end
endmodule
